/* lmr_pkg.sv */
// package for the logic/move/rotate execution unit
// assumes a 14-bit single-word instruction and an 8-bit data path
package lmr_pkg;
    // opcode field widths and reset values
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    // field positions
    localparam int DEST_BIT = 7;
    // instruction encodings
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_RET_IRQ = 14'h0009;
    localparam logic [5:0] OP_STORE_HI = 6'h00;
    localparam logic [5:0] OP_OR_REG_HI = 6'h04;
    localparam logic [5:0] OP_COPY_HI = 6'h08;
    localparam logic [5:0] OP_ROTATE_HI = 6'h0D;
    localparam logic [5:0] OP_OR_LIT_HI = 6'h38;
    localparam logic [3:0] OP_LOAD_LIT_HI = 4'hC;
    typedef enum logic [2:0] {
        exec_none, exec_store, exec_or_reg, exec_copy, exec_rotate, exec_or_lit, exec_load_lit, exec_ret
    } exec_op_t;
endpackage

/* lmr_exec.sv */
// one-cycle execution of or/move/rotate/return instructions
// assumes the file register value for the addressed register arrives in the same cycle
`timescale 1ns/1ns
module logic_move_rotate_exec (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // instruction issue
    input wire logic i_insn_valid,
    input wire logic [13:0] i_insn,
    // file register read data and stack
    input wire logic [7:0] i_file_rdata,
    input wire logic [12:0] i_stack_top,
    // file register write port
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    // architectural state
    output logic [7:0] o_acc,
    output logic o_result_null_flag,
    output logic o_rotate_out_bit,
    output logic o_global_irq_enable,
    output logic o_pc_load,
    output logic [12:0] o_pc_value,
    output logic o_stack_pop
);
    ////////////////////////////////////////////////////////////////////
    lmr_pkg::exec_op_t op;
    logic dest_reg;
    logic [7:0] result;
    logic [7:0] lit;
    logic [6:0] faddr;
    logic [7:0] next_acc;
    logic next_null, next_carry, next_irq_en;
    logic next_file_we, next_pc_load, next_pop;
    logic [7:0] next_file_wdata;
    logic [6:0] next_file_addr;
    logic [12:0] next_pc_value;
    logic write_flag_z;

    // decode: fields and operation class
    // the return word sits inside the store pattern with bit 7 low, so it is matched first
    always_comb begin
        lit = i_insn[7:0];
        faddr = i_insn[6:0];
        dest_reg = i_insn[lmr_pkg::DEST_BIT];
        op = lmr_pkg::exec_none;
        if (i_insn_valid) begin
            if (i_insn == lmr_pkg::OP_RET_IRQ) begin
                op = lmr_pkg::exec_ret;
            end else if (i_insn[13:10] == lmr_pkg::OP_LOAD_LIT_HI) begin
                op = lmr_pkg::exec_load_lit;
            end else if (i_insn[13:8] == lmr_pkg::OP_OR_LIT_HI) begin
                op = lmr_pkg::exec_or_lit;
            end else if (i_insn[13:8] == lmr_pkg::OP_OR_REG_HI) begin
                op = lmr_pkg::exec_or_reg;
            end else if (i_insn[13:8] == lmr_pkg::OP_COPY_HI) begin
                op = lmr_pkg::exec_copy;
            end else if (i_insn[13:8] == lmr_pkg::OP_ROTATE_HI) begin
                op = lmr_pkg::exec_rotate;
            end else if (i_insn[13:8] == lmr_pkg::OP_STORE_HI && dest_reg) begin
                op = lmr_pkg::exec_store;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // execute: compute result and next state; nop and unknown opcodes change nothing but the file address
    always_comb begin
        result = 8'h00;
        write_flag_z = 1'b0;
        next_acc = o_acc;
        next_null = o_result_null_flag;
        next_carry = o_rotate_out_bit;
        next_irq_en = o_global_irq_enable;
        next_file_we = 1'b0;
        // address follows the field every cycle; only the strobe marks a real write
        next_file_addr = faddr;
        next_file_wdata = o_file_wdata;
        next_pc_load = 1'b0;
        next_pc_value = o_pc_value;
        next_pop = 1'b0;
        unique case (op)
            lmr_pkg::exec_or_lit: begin
                next_acc = o_acc | lit;
                next_null = ((o_acc | lit) == 8'h00);
            end
            lmr_pkg::exec_load_lit: begin
                next_acc = lit;
            end
            lmr_pkg::exec_store: begin
                next_file_we = 1'b1;
                next_file_wdata = o_acc;
            end
            lmr_pkg::exec_or_reg: begin
                result = o_acc | i_file_rdata;
                write_flag_z = 1'b1;
            end
            lmr_pkg::exec_copy: begin
                result = i_file_rdata;
                write_flag_z = 1'b1;
            end
            lmr_pkg::exec_rotate: begin
                result = {i_file_rdata[6:0], o_rotate_out_bit};
                next_carry = i_file_rdata[7];
            end
            lmr_pkg::exec_ret: begin
                next_pc_load = 1'b1;
                next_pc_value = i_stack_top;
                next_pop = 1'b1;
                next_irq_en = 1'b1;
            end
            lmr_pkg::exec_none: begin
            end
        endcase
        // destination routing for register-form instructions
        // rotate keeps write_flag_z low, so the zero flag is left alone for it
        if (op == lmr_pkg::exec_or_reg || op == lmr_pkg::exec_copy || op == lmr_pkg::exec_rotate) begin
            if (dest_reg) begin
                next_file_we = 1'b1;
                next_file_wdata = result;
            end else begin
                next_acc = result;
            end
            if (write_flag_z) begin
                next_null = (result == 8'h00);
            end
        end
    end

    // state registers
    // reset branch loads constants only, so the async path carries no logic
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_acc <= lmr_pkg::ACC_RESET;
            o_result_null_flag <= 1'b0;
            o_rotate_out_bit <= 1'b0;
            o_global_irq_enable <= 1'b0;
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_wdata <= 8'h00;
            o_pc_load <= 1'b0;
            o_pc_value <= lmr_pkg::PC_RESET;
            o_stack_pop <= 1'b0;
        end else begin
            o_acc <= next_acc;
            o_result_null_flag <= next_null;
            o_rotate_out_bit <= next_carry;
            o_global_irq_enable <= next_irq_en;
            o_file_we <= next_file_we;
            o_file_addr <= next_file_addr;
            o_file_wdata <= next_file_wdata;
            o_pc_load <= next_pc_load;
            o_pc_value <= next_pc_value;
            o_stack_pop <= next_pop;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_or_lit_acc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_or_lit |=> o_acc == ($past(o_acc) | $past(lit)) && o_result_null_flag == (o_acc == 8'h00))
        else $error("or literal result wrong");
    chk_load_lit_flags: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_load_lit |=> o_acc == $past(lit) && $stable(o_result_null_flag) && $stable(o_rotate_out_bit))
        else $error("load literal wrong");
    chk_or_reg_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_or_reg |=> o_result_null_flag == (($past(o_acc) | $past(i_file_rdata)) == 8'h00))
        else $error("or register zero flag wrong");
    chk_dest_acc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_copy && !dest_reg) |=> !o_file_we && o_acc == $past(i_file_rdata))
        else $error("destination accumulator wrong");
    chk_dest_file: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_or_reg && dest_reg) |=> o_file_we && $stable(o_acc) && o_file_addr == $past(faddr))
        else $error("destination register wrong");
    chk_store_acc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_store |=> o_file_we && o_file_wdata == o_acc && $stable(o_result_null_flag))
        else $error("store accumulator wrong");
    chk_copy_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_copy |=> o_result_null_flag == ($past(i_file_rdata) == 8'h00))
        else $error("copy zero test wrong");
    chk_rotate_carry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_rotate && dest_reg) |=> o_rotate_out_bit == $past(i_file_rdata[7])
            && o_file_wdata == {$past(i_file_rdata[6:0]), $past(o_rotate_out_bit)})
        else $error("rotate through carry wrong");
    chk_ret_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_ret |=> o_pc_load && o_stack_pop && o_global_irq_enable
            && o_pc_value == $past(i_stack_top) && $stable(o_result_null_flag)
            ##1 (!o_pc_load || $past(op) == lmr_pkg::exec_ret))
        else $error("return from irq wrong");
    // refused and idle cycles, and the destination paths left open above
    // back-to-back issue is legal, so pulse checks allow a following return
    chk_idle_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_insn_valid |=> $stable(o_acc) && $stable(o_result_null_flag) && $stable(o_rotate_out_bit)
            && !o_file_we && !o_pc_load)
        else $error("idle cycle changed state");
    chk_store_refused: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_insn_valid && i_insn[13:7] == 7'h00 && i_insn != lmr_pkg::OP_RET_IRQ) |=> !o_file_we && $stable(o_acc))
        else $error("store with clear bit 7 wrote");
    chk_irq_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_global_irq_enable |=> o_global_irq_enable)
        else $error("irq enable dropped");
    chk_rotate_acc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_rotate && !dest_reg) |=> !o_file_we
            && o_acc == {$past(i_file_rdata[6:0]), $past(o_rotate_out_bit)})
        else $error("rotate into accumulator wrong");
    chk_rotate_null: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        op == lmr_pkg::exec_rotate |=> $stable(o_result_null_flag))
        else $error("rotate touched zero flag");
    chk_copy_file: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_copy && dest_reg) |=> o_file_we && $stable(o_acc)
            && o_file_wdata == $past(i_file_rdata))
        else $error("copy to register wrong");
    chk_or_reg_acc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_or_reg && !dest_reg) |=> o_acc == ($past(o_acc) | $past(i_file_rdata)))
        else $error("or register into accumulator wrong");
    chk_or_reg_wdata: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (op == lmr_pkg::exec_or_reg && dest_reg) |=> o_file_wdata == ($past(o_acc) | $past(i_file_rdata)))
        else $error("or register write data wrong");
endmodule

/* tb_top.sv */
// testbench for the or/move/rotate/return execution unit
// assumes one-cycle execution and a combinational file read by the bench
`timescale 1ns/1ns
module tb_top;
    logic i_core_clk, i_sys_rst, i_insn_valid;
    logic [13:0] i_insn;
    logic [7:0] i_file_rdata;
    logic [12:0] i_stack_top;
    logic o_file_we, o_result_null_flag, o_rotate_out_bit, o_global_irq_enable, o_pc_load, o_stack_pop;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata, o_acc;
    logic [12:0] o_pc_value;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    logic_move_rotate_exec uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_insn_valid(i_insn_valid),
        .i_insn(i_insn), .i_file_rdata(i_file_rdata), .i_stack_top(i_stack_top), .o_file_we(o_file_we),
        .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_acc(o_acc),
        .o_result_null_flag(o_result_null_flag), .o_rotate_out_bit(o_rotate_out_bit),
        .o_global_irq_enable(o_global_irq_enable), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_stack_pop(o_stack_pop));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under 200 cycles
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    // verdict in one place
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // value compare, unknowns never match
    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // issue one instruction at a falling edge, drop valid after the taking edge
    task automatic run(input logic [13:0] insn, input logic [7:0] rd);
        @(negedge i_core_clk);
        i_insn = insn;
        i_file_rdata = rd;
        i_insn_valid = 1'b1;
        @(negedge i_core_clk);
        i_insn_valid = 1'b0;
    endtask
    // accumulator and both flags together
    task automatic st(input logic [7:0] a, input logic z, input logic c);
        chk("acc", {5'h00, a}, {5'h00, o_acc});
        chk("null", {12'h000, z}, {12'h000, o_result_null_flag});
        chk("carry", {12'h000, c}, {12'h000, o_rotate_out_bit});
    endtask
    // write port pulse with address and data
    task automatic wr(input logic [6:0] ad, input logic [7:0] d);
        chk("we", 13'h0001, {12'h000, o_file_we});
        chk("addr", {6'h00, ad}, {6'h00, o_file_addr});
        chk("wdata", {5'h00, d}, {5'h00, o_file_wdata});
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_or_lit();
        run(14'h3800, 8'h00);
        st(8'h00, 1'b1, 1'b0);
        run(14'h38A0, 8'h00);
        run(14'h3855, 8'h00);
        st(8'hF5, 1'b0, 1'b0);
    endtask
    // clear the accumulator first so that an untouched null flag reads as set
    task automatic t_load();
        run(14'h0805, 8'h00);
        st(8'h00, 1'b1, 1'b0);
        run(14'h33A5, 8'h00);
        st(8'hA5, 1'b1, 1'b0);
    endtask
    // store, then a store pattern with bit 7 low that must do nothing
    task automatic t_store();
        run(14'h00A3, 8'h00);
        wr(7'h23, 8'hA5);
        st(8'hA5, 1'b1, 1'b0);
        @(negedge i_core_clk);
        chk("we", 13'h0000, {12'h000, o_file_we});
        run(14'h0023, 8'h00);
        chk("we", 13'h0000, {12'h000, o_file_we});
        st(8'hA5, 1'b1, 1'b0);
    endtask
    task automatic t_or_reg();
        run(14'h0405, 8'h0A);
        st(8'hAF, 1'b0, 1'b0);
        chk("we", 13'h0000, {12'h000, o_file_we});
        run(14'h0485, 8'h50);
        wr(7'h05, 8'hFF);
        st(8'hAF, 1'b0, 1'b0);
    endtask
    task automatic t_copy();
        run(14'h0885, 8'h00);
        wr(7'h05, 8'h00);
        st(8'hAF, 1'b1, 1'b0);
        run(14'h0805, 8'h3C);
        st(8'h3C, 1'b0, 1'b0);
    endtask
    // last check: the held rotate word with valid low must not rotate again
    task automatic t_rot();
        run(14'h0D85, 8'h80);
        wr(7'h05, 8'h00);
        st(8'h3C, 1'b0, 1'b1);
        run(14'h0D05, 8'h41);
        st(8'h83, 1'b0, 1'b0);
        @(negedge i_core_clk);
        st(8'h83, 1'b0, 1'b0);
    endtask
    task automatic t_ret();
        run(14'h0009, 8'h00);
        st(8'h83, 1'b0, 1'b0);
        chk("pc_load", 13'h0001, {12'h000, o_pc_load});
        chk("pop", 13'h0001, {12'h000, o_stack_pop});
        chk("pc", 13'h1ABC, o_pc_value);
        chk("irq_enable", 13'h0001, {12'h000, o_global_irq_enable});
        run(14'h0000, 8'hFF);
        st(8'h83, 1'b0, 1'b0);
        chk("pc_load", 13'h0000, {12'h000, o_pc_load});
        chk("irq_enable", 13'h0001, {12'h000, o_global_irq_enable});
    endtask
    // mid-run reset for one edge, then an instruction at the first edge after release
    task automatic t_reset();
        @(negedge i_core_clk);
        i_sys_rst = 1'b1;
        @(negedge i_core_clk);
        st(8'h00, 1'b0, 1'b0);
        chk("irq_enable", 13'h0000, {12'h000, o_global_irq_enable});
        i_sys_rst = 1'b0;
        i_insn = 14'h3800;
        i_file_rdata = 8'h00;
        i_insn_valid = 1'b1;
        @(negedge i_core_clk);
        i_insn_valid = 1'b0;
        st(8'h00, 1'b1, 1'b0);
        chk("irq_enable", 13'h0000, {12'h000, o_global_irq_enable});
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence: reset for five cycles, inputs move on falling edges
    initial begin
        i_sys_rst = 1'b1;
        i_insn_valid = 1'b0;
        i_insn = 14'h0000;
        i_file_rdata = 8'h00;
        i_stack_top = 13'h1ABC;
        repeat (5) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        t_or_lit();
        t_load();
        t_store();
        t_or_reg();
        t_copy();
        t_rot();
        t_ret();
        t_reset();
        end_of_test();
    end
endmodule
